// File: src/rss_pkg.sv
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
// Summary of operation
// [RL1] six reset kinds kept apart: supply-rise, watchdog, pin, low-supply, awake or asleep
// [RL2] register-init pulse on supply-rise, pin, watchdog and low-supply resets
// [RL3] watchdog timeout while asleep wakes the core without register init
// [RL4] some registers never initialised; unknown after supply-rise, kept otherwise
// [RL5] watchdog-expired and sleep-entered flags updated per reset kind
// [RL6] external pin passes a filter that drops short low pulses
// [RL7] watchdog reset stays internal, pin is never driven low
// [RL8] pin enable cleared: pin reset inactive, weak pull-up on
// [RL9] programming entry through the pin works whatever the pin option
// [RL10] settle timer gives 64 ms, only after supply-rise or low-supply resets
// [RL11] settle timer counts the 31 kHz slow internal oscillator
// [RL12] internal reset held while the settle timer runs
// [RL13] settle timer disable bit: 1 disables, 0 enables
// [RL14] low-supply reset enable does not switch on the settle timer
// [RL15] configuring party should enable settle timer with low-supply reset
// [RL16] reset held while supply-rise detector reports supply too low
// [RL17] with low-supply reset on, reset held until supply above threshold
// [RL18] no reset on falling supply; re-arm after 100 us at ground
// [RL19] clearing data protection erases all data nonvolatile memory
// [RL20] clearing program protection erases all program memory
// [RL21] pin asserted in internal or RC oscillator mode stops the oscillator
// [RL22] supply-rise flag bit 1 cleared by supply-rise reset only, software sets
// [RL23] low-supply flag bit 0 cleared by low-supply reset
// [RL24] supply dip during settle re-enters low-supply reset, timer restarts
// [RL25] settle timer is a counter of slow-oscillator cycles, 1984 at 31 kHz
package rss_pkg;

  // ----------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h08;
  localparam logic [7:0] ADDR_CORE_FLAGS = 8'h0C;

  // config register fields
  localparam int CFG_PIN_EN = 0;
  localparam int CFG_SETTLE_DIS = 1;
  localparam int CFG_LOW_SUP_EN = 2;
  localparam int CFG_OSC_LSB = 3;
  localparam int CFG_PROG_PROT = 6;
  localparam int CFG_DATA_PROT = 7;
  localparam logic [7:0] CONFIG_RESET = 8'hFB;

  // power-control and core flag fields
  localparam int PWR_LOW_SUPPLY = 0;
  localparam int PWR_SUPPLY_RISE = 1;
  localparam int FLG_SLEEP_ENTERED = 0;
  localparam int FLG_WDT_EXPIRED = 1;
  localparam logic [1:0] POWER_CTRL_RESET = 2'h0;
  localparam logic [1:0] CORE_FLAGS_RESET = 2'h3;

  // status register fields
  localparam int ST_KIND_LSB = 0;
  localparam int ST_RESET = 3;
  localparam int ST_SETTLE = 4;
  localparam int ST_RETAINED_UNKNOWN = 5;

  // oscillator modes that stop under pin reset
  localparam logic [2:0] OSC_RC = 3'h7;
  localparam logic [2:0] OSC_RCIO = 3'h6;
  localparam logic [2:0] OSC_INT = 3'h5;
  localparam logic [2:0] OSC_INTIO = 3'h4;

  // ----------------------------------------------------------
  // timing
  // ----------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int SETTLE_MS = 64;
  localparam int SLOW_OSC_HZ = 31000;
  localparam int SETTLE_SLOW_CYCLES = (SETTLE_MS * SLOW_OSC_HZ) / 1000;
  localparam int GROUND_US = 100;
  localparam int GROUND_CYCLES = GROUND_US * CLK_MHZ;
  localparam int PIN_FILTER_CYCLES = 8;

  typedef enum logic [2:0] {
    KIND_NONE, KIND_SUPPLY_RISE, KIND_WDT_RUN, KIND_WDT_SLEEP,
    KIND_PIN_RUN, KIND_PIN_SLEEP, KIND_LOW_SUPPLY
  } rss_kind_t;

  typedef enum logic [1:0] {
    SEQ_RUN, SEQ_HOLD, SEQ_SETTLE, SEQ_PIN
  } rss_seq_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rss_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } rss_wb_rsp_t;

endpackage

// File: src/rss_reset_source_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module rss_reset_source_sequencer #(
  parameter int SETTLE_CYCLES = rss_pkg::SETTLE_SLOW_CYCLES,
  parameter int FILTER_CYCLES = rss_pkg::PIN_FILTER_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire rss_pkg::rss_wb_req_t wbReq,
  output rss_pkg::rss_wb_rsp_t wbRsp,
  input wire logic supplyRiseOk,
  input wire logic supplyAtGround,
  input wire logic lowSupplyOk,
  input wire logic slowOscClk,
  input wire logic extResetPinIn,
  output logic extResetPinOut,
  output logic extResetPinOe,
  output logic pinPullupEnable,
  input wire logic progEntryDetect,
  output logic progEntry,
  input wire logic watchdogTimeout,
  input wire logic sleepActive,
  output logic internalReset,
  output logic regInit,
  output logic retainedUnknown,
  output logic oscStop,
  output logic eraseData,
  output logic eraseProgram,
  output rss_pkg::rss_kind_t resetKind
);

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  // three stages; a level is taken once stages two and three agree
  logic [2:0] supOkSync_q, gndSync_q, lowOkSync_q, oscSync_q, pinSync_q, progSync_q;
  logic supOk_q, gnd_q, lowOk_q, osc_q, pinLvl_q, prog_q;

  function automatic logic settled(input logic [2:0] s, input logic prev);
    settled = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  always_ff @(posedge clock) begin
    if (rst) begin
      supOkSync_q <= 3'h0;
      gndSync_q <= 3'h0;
      lowOkSync_q <= 3'h7;
      oscSync_q <= 3'h0;
      pinSync_q <= 3'h7;
      progSync_q <= 3'h0;
      supOk_q <= 1'b0;
      gnd_q <= 1'b0;
      lowOk_q <= 1'b1;
      osc_q <= 1'b0;
      pinLvl_q <= 1'b1;
      prog_q <= 1'b0;
    end else begin
      supOkSync_q <= {supOkSync_q[1:0], supplyRiseOk};
      gndSync_q <= {gndSync_q[1:0], supplyAtGround};
      lowOkSync_q <= {lowOkSync_q[1:0], lowSupplyOk};
      oscSync_q <= {oscSync_q[1:0], slowOscClk};
      pinSync_q <= {pinSync_q[1:0], extResetPinIn};
      progSync_q <= {progSync_q[1:0], progEntryDetect};
      supOk_q <= settled(supOkSync_q, supOk_q);
      gnd_q <= settled(gndSync_q, gnd_q);
      lowOk_q <= settled(lowOkSync_q, lowOk_q);
      osc_q <= settled(oscSync_q, osc_q);
      pinLvl_q <= settled(pinSync_q, pinLvl_q);
      prog_q <= settled(progSync_q, prog_q);
    end
  end

  // ----------------------------------------------------------
  // configuration and software registers
  // ----------------------------------------------------------
  logic [7:0] config_q;
  logic [1:0] powerCtrl_q;
  logic [1:0] coreFlags_q;
  logic retained_q;
  logic busWrite, busRead;
  logic [2:0] oscMode;
  logic pinEnable, settleDisable, lowSupEnable;

  assign busWrite = wbReq.cyc && wbReq.stb && wbReq.we && !wbRsp.ack && wbReq.sel[0];
  assign busRead = wbReq.cyc && wbReq.stb && !wbReq.we && !wbRsp.ack;
  assign oscMode = config_q[rss_pkg::CFG_OSC_LSB +: 3];
  assign pinEnable = config_q[rss_pkg::CFG_PIN_EN];
  // [RL13] disable bit polarity
  assign settleDisable = config_q[rss_pkg::CFG_SETTLE_DIS];
  // [RL14] separate enables
  assign lowSupEnable = config_q[rss_pkg::CFG_LOW_SUP_EN];

  always_ff @(posedge clock) begin
    if (rst) begin
      config_q <= rss_pkg::CONFIG_RESET;
    end else if (busWrite && wbReq.adr == rss_pkg::ADDR_CONFIG) begin
      config_q <= wbReq.dat[7:0];
    end
  end

  // ----------------------------------------------------------
  // protection release erase
  // ----------------------------------------------------------
  // only a 0 to 1 change of a protect bit (protection off) erases
  always_ff @(posedge clock) begin
    if (rst) begin
      eraseData <= 1'b0;
      eraseProgram <= 1'b0;
    end else begin
      // [RL19] data erase
      eraseData <= busWrite && wbReq.adr == rss_pkg::ADDR_CONFIG &&
                   !config_q[rss_pkg::CFG_DATA_PROT] && wbReq.dat[rss_pkg::CFG_DATA_PROT];
      // [RL20] program erase
      eraseProgram <= busWrite && wbReq.adr == rss_pkg::ADDR_CONFIG &&
                      !config_q[rss_pkg::CFG_PROG_PROT] && wbReq.dat[rss_pkg::CFG_PROG_PROT];
    end
  end

  // ----------------------------------------------------------
  // external pin filter
  // ----------------------------------------------------------
  logic [7:0] lowCount_q;
  logic pinAsserted_q;

  // [RL6] short lows ignored
  always_ff @(posedge clock) begin
    if (rst) begin
      lowCount_q <= 8'h00;
      pinAsserted_q <= 1'b0;
    end else if (!pinEnable || pinLvl_q) begin
      // [RL8] disabled pin never resets
      lowCount_q <= 8'h00;
      pinAsserted_q <= 1'b0;
    end else if (lowCount_q >= 8'(FILTER_CYCLES - 1)) begin
      pinAsserted_q <= 1'b1;
    end else begin
      lowCount_q <= lowCount_q + 8'h01;
    end
  end

  // ----------------------------------------------------------
  // supply-rise detector arming
  // ----------------------------------------------------------
  logic [12:0] gndCount_q;
  logic armed_q;
  logic porHold, borHold;

  // [RL18] falling supply alone never re-arms
  always_ff @(posedge clock) begin
    if (rst) begin
      gndCount_q <= 13'h0000;
      armed_q <= 1'b1;
    end else if (!gnd_q) begin
      gndCount_q <= 13'h0000;
      if (supOk_q) begin
        armed_q <= 1'b0;
      end
    end else if (gndCount_q >= 13'(rss_pkg::GROUND_CYCLES - 1)) begin
      armed_q <= 1'b1;
    end else begin
      gndCount_q <= gndCount_q + 13'h0001;
    end
  end

  // [RL16] hold while armed and supply not at operating level
  assign porHold = armed_q && !supOk_q;
  // [RL17] hold until above threshold
  assign borHold = lowSupEnable && !lowOk_q;

  // ----------------------------------------------------------
  // reset events
  // ----------------------------------------------------------
  logic porPrev_q, borPrev_q, pinPrev_q;
  logic evPor, evBor, evPin, evWdt;

  always_ff @(posedge clock) begin
    if (rst) begin
      porPrev_q <= 1'b0;
      borPrev_q <= 1'b0;
      pinPrev_q <= 1'b0;
    end else begin
      porPrev_q <= porHold;
      borPrev_q <= borHold;
      pinPrev_q <= pinAsserted_q;
    end
  end

  assign evPor = porHold && !porPrev_q;
  assign evBor = borHold && !borPrev_q && !evPor;
  assign evPin = pinAsserted_q && !pinPrev_q && !evPor && !evBor;
  assign evWdt = watchdogTimeout && !evPor && !evBor && !evPin;

  // [RL1] kind of the last reset
  always_ff @(posedge clock) begin
    if (rst) begin
      resetKind <= rss_pkg::KIND_NONE;
    end else if (evPor) begin
      resetKind <= rss_pkg::KIND_SUPPLY_RISE;
    end else if (evBor) begin
      resetKind <= rss_pkg::KIND_LOW_SUPPLY;
    end else if (evPin) begin
      resetKind <= sleepActive ? rss_pkg::KIND_PIN_SLEEP : rss_pkg::KIND_PIN_RUN;
    end else if (evWdt) begin
      resetKind <= sleepActive ? rss_pkg::KIND_WDT_SLEEP : rss_pkg::KIND_WDT_RUN;
    end
  end

  // ----------------------------------------------------------
  // sequencer and settle timer
  // ----------------------------------------------------------
  rss_pkg::rss_seq_t seq_q;
  logic [11:0] settleCount_q;
  logic oscPrev_q;
  logic slowTick;

  // [RL11] slow oscillator edges clock the count
  assign slowTick = osc_q && !oscPrev_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      oscPrev_q <= 1'b0;
    end else begin
      oscPrev_q <= osc_q;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      seq_q <= rss_pkg::SEQ_RUN;
      settleCount_q <= 12'h000;
    end else begin
      case (seq_q)
        rss_pkg::SEQ_RUN: begin
          if (porHold || borHold) begin
            seq_q <= rss_pkg::SEQ_HOLD;
          end else if (pinAsserted_q) begin
            seq_q <= rss_pkg::SEQ_PIN;
          end
        end
        rss_pkg::SEQ_HOLD: begin
          settleCount_q <= 12'h000;
          if (!porHold && !borHold) begin
            // [RL10] timer only after supply resets
            seq_q <= settleDisable ? rss_pkg::SEQ_RUN : rss_pkg::SEQ_SETTLE;
          end
        end
        rss_pkg::SEQ_SETTLE: begin
          if (porHold || borHold) begin
            // [RL24] dip restarts timer
            seq_q <= rss_pkg::SEQ_HOLD;
            settleCount_q <= 12'h000;
          end else if (settleCount_q >= 12'(SETTLE_CYCLES)) begin
            seq_q <= rss_pkg::SEQ_RUN;
          end else if (slowTick) begin
            // [RL25] count slow cycles
            settleCount_q <= settleCount_q + 12'h001;
          end
        end
        rss_pkg::SEQ_PIN: begin
          // pin reset never starts the settle timer
          if (porHold || borHold) begin
            seq_q <= rss_pkg::SEQ_HOLD;
          end else if (!pinAsserted_q) begin
            seq_q <= rss_pkg::SEQ_RUN;
          end
        end
        default: begin
          seq_q <= rss_pkg::SEQ_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // reset outputs
  // ----------------------------------------------------------
  logic wdtReset;

  // [RL3] watchdog in sleep is a wake-up
  assign wdtReset = evWdt && !sleepActive;

  always_ff @(posedge clock) begin
    if (rst) begin
      internalReset <= 1'b1;
      regInit <= 1'b0;
    end else begin
      // [RL12] held while settling, [RL7] watchdog reset kept internal
      internalReset <= seq_q != rss_pkg::SEQ_RUN || porHold || borHold || pinAsserted_q || wdtReset;
      // [RL2] one init pulse per reset event
      regInit <= evPor || evBor || evPin || wdtReset;
    end
  end

  // [RL4] retained registers flagged unknown after supply-rise only
  always_ff @(posedge clock) begin
    if (rst) begin
      retained_q <= 1'b1;
    end else if (evPor) begin
      retained_q <= 1'b1;
    end else if (busWrite && wbReq.adr == rss_pkg::ADDR_STATUS && wbReq.dat[rss_pkg::ST_RETAINED_UNKNOWN]) begin
      retained_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // cause flags
  // ----------------------------------------------------------
  // a hardware event wins over a software write in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      powerCtrl_q <= rss_pkg::POWER_CTRL_RESET;
    end else if (evPor) begin
      // [RL22] cleared on supply-rise only
      powerCtrl_q[rss_pkg::PWR_SUPPLY_RISE] <= 1'b0;
    end else if (evBor) begin
      // [RL23] low-supply flag cleared
      powerCtrl_q[rss_pkg::PWR_LOW_SUPPLY] <= 1'b0;
    end else if (busWrite && wbReq.adr == rss_pkg::ADDR_POWER_CTRL) begin
      powerCtrl_q <= powerCtrl_q | wbReq.dat[1:0];
    end
  end

  // [RL5] flag pattern per reset kind
  always_ff @(posedge clock) begin
    if (rst) begin
      coreFlags_q <= rss_pkg::CORE_FLAGS_RESET;
    end else if (evPor || evBor) begin
      coreFlags_q <= 2'h3;
    end else if (evPin && sleepActive) begin
      coreFlags_q[rss_pkg::FLG_WDT_EXPIRED] <= 1'b1;
      coreFlags_q[rss_pkg::FLG_SLEEP_ENTERED] <= 1'b0;
    end else if (evWdt) begin
      coreFlags_q[rss_pkg::FLG_WDT_EXPIRED] <= 1'b0;
      if (sleepActive) begin
        coreFlags_q[rss_pkg::FLG_SLEEP_ENTERED] <= 1'b0;
      end
    end else if (busWrite && wbReq.adr == rss_pkg::ADDR_CORE_FLAGS) begin
      coreFlags_q <= wbReq.dat[1:0];
    end
  end

  // ----------------------------------------------------------
  // pin and oscillator controls
  // ----------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      extResetPinOut <= 1'b0;
      extResetPinOe <= 1'b0;
      pinPullupEnable <= 1'b0;
      progEntry <= 1'b0;
      oscStop <= 1'b0;
    end else begin
      // [RL7] pin is input only
      extResetPinOut <= 1'b0;
      extResetPinOe <= 1'b0;
      // [RL8] pull-up with internal option
      pinPullupEnable <= !pinEnable;
      // [RL9] programming entry ignores the pin option
      progEntry <= prog_q;
      // [RL21] stop oscillator under pin reset
      oscStop <= pinAsserted_q && (oscMode == rss_pkg::OSC_RC || oscMode == rss_pkg::OSC_RCIO ||
                                   oscMode == rss_pkg::OSC_INT || oscMode == rss_pkg::OSC_INTIO);
    end
  end

  assign retainedUnknown = retained_q;

  // ----------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------
  // one wait state keeps read data registered
  always_ff @(posedge clock) begin
    if (rst) begin
      wbRsp <= '0;
    end else begin
      wbRsp.ack <= wbReq.cyc && wbReq.stb && !wbRsp.ack;
      wbRsp.dat <= 32'h0000_0000;
      if (busRead) begin
        if (wbReq.adr == rss_pkg::ADDR_CONFIG) begin
          wbRsp.dat <= {24'h000000, config_q};
        end else if (wbReq.adr == rss_pkg::ADDR_STATUS) begin
          wbRsp.dat <= {26'h0000000, retained_q, seq_q == rss_pkg::SEQ_SETTLE, internalReset, resetKind};
        end else if (wbReq.adr == rss_pkg::ADDR_POWER_CTRL) begin
          wbRsp.dat <= {30'h00000000, powerCtrl_q};
        end else if (wbReq.adr == rss_pkg::ADDR_CORE_FLAGS) begin
          wbRsp.dat <= {30'h00000000, coreFlags_q};
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: test/rss_reset_source_sequencer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rss_reset_source_sequencer_monitor #(
  parameter int SETTLE_CYCLES = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire rss_pkg::rss_wb_req_t wbReq,
  input wire rss_pkg::rss_wb_rsp_t wbRsp,
  input wire logic slowOscClk,
  input wire logic extResetPinOut,
  input wire logic extResetPinOe,
  input wire logic pinPullupEnable,
  input wire logic watchdogTimeout,
  input wire logic sleepActive,
  input wire logic internalReset,
  input wire logic regInit,
  input wire logic eraseData,
  input wire logic eraseProgram,
  input wire rss_pkg::rss_kind_t resetKind
);
  // ----------------------------------------
  // shadow config and slow edge count
  // ----------------------------------------
  logic [7:0] cfg_q;
  logic slowPrev_q;
  int slowEdges_q;
  always_ff @(posedge clock) begin
    if (rst)
      cfg_q <= rss_pkg::CONFIG_RESET;
    else if (wbReq.cyc && wbReq.stb && wbReq.we && wbReq.sel[0] && !wbRsp.ack && wbReq.adr == rss_pkg::ADDR_CONFIG)
      cfg_q <= wbReq.dat[7:0];
  end
  always_ff @(posedge clock) begin
    slowPrev_q <= slowOscClk;
  end
  // raw edges, so never fewer than the design's synced count
  always_ff @(posedge clock) begin
    if (rst || !internalReset)
      slowEdges_q <= 0;
    else if (slowOscClk && !slowPrev_q)
      slowEdges_q <= slowEdges_q + 1;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_pin_never_driven: assert property (!extResetPinOut && !extResetPinOe)
    else $error("reset pin driven");
  a_pullup_follows_cfg: assert property (pinPullupEnable == !$past(cfg_q[rss_pkg::CFG_PIN_EN]))
    else $error("pull-up does not follow pin enable");
  a_erase_data_pulse: assert property (eraseData == (cfg_q[7] && !$past(cfg_q[7])))
    else $error("data erase pulse wrong");
  a_erase_prog_pulse: assert property (eraseProgram == (cfg_q[6] && !$past(cfg_q[6])))
    else $error("program erase pulse wrong");
  a_init_one_cycle: assert property (regInit |=> !regInit)
    else $error("init pulse too long");
  a_wdt_awake_init: assert property (watchdogTimeout && !sleepActive && !internalReset
    |=> (regInit && internalReset && resetKind == rss_pkg::KIND_WDT_RUN) ##1 !internalReset) else $error("watchdog reset wrong");
  a_wdt_sleep_wake: assert property (watchdogTimeout && sleepActive && !internalReset
    |=> !regInit && !internalReset && resetKind == rss_pkg::KIND_WDT_SLEEP) else $error("watchdog wake wrong");
  a_settle_hold_len: assert property ($fell(internalReset) && !cfg_q[rss_pkg::CFG_SETTLE_DIS]
    && (resetKind == rss_pkg::KIND_SUPPLY_RISE || resetKind == rss_pkg::KIND_LOW_SUPPLY)
    |-> slowEdges_q >= SETTLE_CYCLES) else $error("settle hold too short");
endmodule
`default_nettype wire

// File: test/rss_supply_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module rss_supply_pin_model (
  input wire logic clock,
  input wire logic [1:0] supplyLevel,
  input wire logic dipCmd,
  input wire logic pinLowCmd,
  output logic supplyRiseOk,
  output logic supplyAtGround,
  output logic lowSupplyOk,
  output logic slowOscClk,
  output logic extResetPinIn
);
  // ----------------------------------------
  // detectors, slow oscillator, pin
  // ----------------------------------------
  logic [2:0] div_q = 3'h0;
  logic slow_q = 1'b0;
  // level 0 ground, 1 sagging, 2 good
  assign supplyAtGround = (supplyLevel == 2'h0);
  assign supplyRiseOk = (supplyLevel == 2'h2);
  assign lowSupplyOk = (supplyLevel == 2'h2) && !dipCmd;
  always_ff @(posedge clock) begin
    div_q <= div_q + 3'h1;
    if (div_q == 3'h7)
      slow_q <= !slow_q;
  end
  assign slowOscClk = slow_q;
  // board pull-up holds the pin high unless pulled low
  assign extResetPinIn = !pinLowCmd;
endmodule
`default_nettype wire

// File: test/rss_reset_source_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module rss_reset_source_sequencer_test;
  logic clock, rst, dipCmd, pinLowCmd;
  logic [1:0] supplyLevel;
  rss_pkg::rss_wb_req_t wbReq;
  rss_pkg::rss_wb_rsp_t wbRsp;
  logic supplyRiseOk, supplyAtGround, lowSupplyOk, slowOscClk, extResetPinIn, extResetPinOut, extResetPinOe;
  logic pinPullupEnable, progEntryDetect, progEntry, watchdogTimeout, sleepActive, internalReset;
  logic regInit, retainedUnknown, oscStop, eraseData, eraseProgram;
  rss_pkg::rss_kind_t resetKind;
  int nFail = 0, comparisons = 0, seed = 40553;
  logic [31:0] expQ[$];
  logic [7:0] adrQ[$];
  logic [7:0] cfg;
  rss_reset_source_sequencer #(.SETTLE_CYCLES(4), .FILTER_CYCLES(4)) uut (.clock, .rst, .wbReq, .wbRsp,
    .supplyRiseOk, .supplyAtGround, .lowSupplyOk, .slowOscClk, .extResetPinIn, .extResetPinOut, .extResetPinOe,
    .pinPullupEnable, .progEntryDetect, .progEntry, .watchdogTimeout, .sleepActive, .internalReset, .regInit,
    .retainedUnknown, .oscStop, .eraseData, .eraseProgram, .resetKind);
  rss_supply_pin_model model (.clock, .supplyLevel, .dipCmd, .pinLowCmd, .supplyRiseOk, .supplyAtGround,
    .lowSupplyOk, .slowOscClk, .extResetPinIn);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      nFail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, nFail);
    if (nFail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // request held until the edge that samples ack
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do @(posedge clock); while (wbRsp.ack !== 1'b1);
    wbReq <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back({24'h0, e});
    adrQ.push_back(a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic waitRel();
    for (int i = 0; i < 3000 && internalReset !== 1'b0; i++)
      @(posedge clock);
    check(internalReset, 1'b0, "reset release");
  endtask
  task automatic pulseWdt(input logic s);
    @(posedge clock);
    sleepActive <= s;
    watchdogTimeout <= 1'b1;
    @(posedge clock);
    watchdogTimeout <= 1'b0;
    cyc(4);
    sleepActive <= 1'b0;
  endtask
  task automatic pinReset(input logic s, input logic expHold);
    @(posedge clock);
    sleepActive <= s;
    pinLowCmd <= 1'b1;
    cyc(12);
    check(internalReset, expHold, "pin hold");
    check(oscStop, expHold, "oscillator stop");
    pinLowCmd <= 1'b0;
    sleepActive <= 1'b0;
    waitRel();
    check(oscStop, 1'b0, "oscillator run");
  endtask
  // read results are taken in order as they come back
  always @(posedge clock) begin
    if (wbRsp.ack === 1'b1 && wbReq.we === 1'b0 && expQ.size() > 0)
      check(wbRsp.dat, expQ.pop_front(), $sformatf("register %h", adrQ.pop_front()));
  end
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // whole run needs about 4500 cycles
  initial begin
    #(25 * 40000);
    nFail++;
    $display("unexpected run length expected finish seen hang");
    give_verdict();
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  localparam logic [7:0] CFG = rss_pkg::ADDR_CONFIG, STS = rss_pkg::ADDR_STATUS, PWR = rss_pkg::ADDR_POWER_CTRL,
    FLG = rss_pkg::ADDR_CORE_FLAGS;
  initial begin
    rst = 1'b1;
    wbReq = '0;
    supplyLevel = 2'h2;
    {dipCmd, pinLowCmd, progEntryDetect, watchdogTimeout, sleepActive} = 5'h0;
    cyc(8);
    rst <= 1'b0;
    waitRel();
    check(retainedUnknown, 1'b1, "retained unknown");
    rd(CFG, rss_pkg::CONFIG_RESET);
    rd(PWR, 8'h00);
    rd(FLG, 8'h03);
    rd(STS, 8'h21);
    rd(8'h10, 8'h00);
    $display("test reset values finished");
    wr(PWR, 8'h03);
    wr(FLG, 8'h03);
    wr(STS, 8'h20);
    pulseWdt(1'b0);
    rd(FLG, 8'h01);
    rd(PWR, 8'h03);
    rd(STS, 8'h02);
    wr(FLG, 8'h03);
    pulseWdt(1'b1);
    rd(FLG, 8'h00);
    rd(STS, 8'h03);
    $display("test watchdog finished");
    cfg = {2'b00, 1'b1, 2'($random(seed)), 3'b011};
    wr(CFG, cfg);
    rd(CFG, cfg);
    wr(FLG, 8'h03);
    @(posedge clock);
    pinLowCmd <= 1'b1;
    cyc(2);
    pinLowCmd <= 1'b0;
    cyc(10);
    rd(STS, 8'h03);
    pinReset(1'b0, 1'b1);
    rd(STS, 8'h04);
    rd(FLG, 8'h03);
    pinReset(1'b1, 1'b1);
    rd(STS, 8'h05);
    rd(FLG, 8'h02);
    cfg = {2'b11, cfg[5:3], 3'b010};
    wr(CFG, cfg);
    pinReset(1'b0, 1'b0);
    rd(STS, 8'h05);
    progEntryDetect <= 1'b1;
    cyc(6);
    check(progEntry, 1'b1, "programming entry");
    progEntryDetect <= 1'b0;
    $display("test reset pin finished");
    cfg = {2'b11, cfg[5:3], 3'b001};
    wr(CFG, cfg);
    wr(PWR, 8'h03);
    wr(FLG, 8'h00);
    supplyLevel <= 2'h1;
    cyc(12);
    check(internalReset, 1'b0, "falling supply");
    supplyLevel <= 2'h0;
    cyc(4100);
    supplyLevel <= 2'h1;
    cyc(12);
    check(internalReset, 1'b1, "supply hold");
    supplyLevel <= 2'h2;
    cyc(20);
    check(internalReset, 1'b1, "settle hold");
    waitRel();
    rd(PWR, 8'h01);
    rd(FLG, 8'h03);
    rd(STS, 8'h21);
    wr(STS, 8'h20);
    $display("test supply rise finished");
    // settle timer kept on with low-supply reset
    cfg[2] = 1'b1;
    wr(CFG, cfg);
    wr(PWR, 8'h03);
    wr(FLG, 8'h00);
    dipCmd <= 1'b1;
    cyc(12);
    check(internalReset, 1'b1, "low supply hold");
    dipCmd <= 1'b0;
    cyc(30);
    dipCmd <= 1'b1;
    cyc(12);
    check(internalReset, 1'b1, "dip in settle");
    dipCmd <= 1'b0;
    cyc(20);
    check(internalReset, 1'b1, "settle restart");
    waitRel();
    rd(PWR, 8'h02);
    rd(FLG, 8'h03);
    rd(STS, 8'h06);
    $display("test low supply finished");
    cyc(4);
    give_verdict();
  end
endmodule
bind rss_reset_source_sequencer rss_reset_source_sequencer_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) mon (
  .clock(clock), .rst(rst), .wbReq(wbReq), .wbRsp(wbRsp), .slowOscClk(slowOscClk),
  .extResetPinOut(extResetPinOut), .extResetPinOe(extResetPinOe), .pinPullupEnable(pinPullupEnable),
  .watchdogTimeout(watchdogTimeout), .sleepActive(sleepActive), .internalReset(internalReset),
  .regInit(regInit), .eraseData(eraseData), .eraseProgram(eraseProgram), .resetKind(resetKind));
`default_nettype wire
